// *** core/chgc_regs.sv ***
/*
  Charger configuration registers at 03..05 with loop arbitration, loop
  status latch, detection trigger and derived control outputs.
  Assumes the serial bus engine delivers decoded byte accesses synchronous
  to mclk, and that all status inputs are synchronous to mclk.
*/
`include "chgc_consts.svh"

module chgc_regs
  import chgc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        wdog_expired,
  input  wire logic        ce_pin,
  input  wire logic        input_present,
  input  wire logic        vin_loop_req,
  input  wire logic        ilim_loop_req,
  input  wire logic        therm_loop_req,
  input  wire logic        power_path_active,
  input  wire logic [2:0]  ts_fault_in,
  input  wire logic        detect_done,
  output logic             detect_start,
  output logic             host_mode,
  output logic             ext_charge_mode,
  output logic             term_tenth_mode,
  output logic      [11:0] chg_current_ma,
  output logic      [11:0] term_current_ma,
  output logic      [12:0] vin_floor_mv,
  output logic      [2:0]  loop_in_control,
  output logic             timer_half_speed,
  output logic      [9:0]  timer_limit_min,
  output logic             timer_disabled,
  output logic             batt_switch_off,
  output logic             ts_monitor_en
);
  logic [7:0] curr_reg;
  logic [7:0] loop_ctl_reg;
  logic [7:0] tmr_reg;
  chgc_loop_t grant_reg, grant_next;
  chgc_loop_t status_reg;
  logic       host_reg;
  logic       detect_reg;
  logic [2:0] ts_code;

  chgc_dec_if dif ();

  wire wr_curr = reg_wr && (reg_addr == `CHGC_ADDR_CURR);
  wire wr_loop = reg_wr && (reg_addr == `CHGC_ADDR_LOOP);
  wire wr_tmr  = reg_wr && (reg_addr == `CHGC_ADDR_TMR);
  wire rd_loop = reg_rd && (reg_addr == `CHGC_ADDR_LOOP);
  wire wr_any  = wr_curr || wr_loop || wr_tmr;

  // Fully writable current register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      curr_reg <= `CHGC_RST_CURR;
    else if (wr_curr)
      curr_reg <= reg_wdata;
  end

  // Only the writable bits of 04 are stored; status bits never take host data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      loop_ctl_reg <= `CHGC_RST_LOOP;
    else if (wr_loop)
      loop_ctl_reg <= reg_wdata & `CHGC_LOOP_RW_MASK;
  end

  // Timer/thermistor control; bits 2:0 are status and stay clear here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      tmr_reg <= `CHGC_RST_TMR;
    else if (wr_tmr)
      tmr_reg <= {reg_wdata[7:3], 3'b000};
  end

  // Host mode starts on any write to 03..05; a write in the expiry cycle keeps it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      host_reg <= 1'b0;
    else if (wr_any)
      host_reg <= 1'b1;
    else if (wdog_expired)
      host_reg <= 1'b0;
  end

  // Detection request: a fresh write of one beats a completion in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      detect_reg <= 1'b0;
    else if (wr_loop && reg_wdata[`CHGC_BIT_DETECT])
      detect_reg <= 1'b1;
    else if (detect_done)
      detect_reg <= 1'b0;
  end

  // One start pulse per write of one to the detect bit, independent of input power
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      detect_start <= 1'b0;
    else
      detect_start <= wr_loop && reg_wdata[`CHGC_BIT_DETECT];
  end

  // Arbiter keeps the holder while it still asks, so control never flips mid-loop
  always_comb begin
    grant_next = CHGC_LOOP_NONE;
    if ((grant_reg == CHGC_LOOP_THERM && therm_loop_req) ||
        (grant_reg == CHGC_LOOP_ILIM && ilim_loop_req) ||
        (grant_reg == CHGC_LOOP_VIN && vin_loop_req))
      grant_next = grant_reg;
    else if (therm_loop_req)
      grant_next = CHGC_LOOP_THERM;
    else if (ilim_loop_req)
      grant_next = CHGC_LOOP_ILIM;
    else if (vin_loop_req)
      grant_next = CHGC_LOOP_VIN;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      grant_reg <= CHGC_LOOP_NONE;
    else
      grant_reg <= grant_next;
  end

  // First event sticks; a new event in the read cycle is kept, not lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      status_reg <= CHGC_LOOP_NONE;
    else if ((status_reg == CHGC_LOOP_NONE || rd_loop) && grant_reg != CHGC_LOOP_NONE)
      status_reg <= grant_reg;
    else if (rd_loop)
      status_reg <= CHGC_LOOP_NONE;
  end

  // Disabled monitoring reads as open
  assign ts_code = tmr_reg[`CHGC_BIT_THERMISTOR_MONITOR_ENABLE] ? ts_fault_in : `CHGC_TS_OPEN;

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        `CHGC_ADDR_CURR: reg_rdata <= curr_reg;
        `CHGC_ADDR_LOOP: reg_rdata <= {status_reg, loop_ctl_reg[5], detect_reg,
                                       ce_pin, loop_ctl_reg[2:0]};
        `CHGC_ADDR_TMR:  reg_rdata <= {tmr_reg[7:3], ts_code};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  // Codes to the decoder
  assign dif.fast_charge_current_code  = curr_reg[7:3];
  assign dif.termination_current_code = curr_reg[2:0];
  assign dif.vin_code   = loop_ctl_reg[2:0];
  assign dif.reduced    = loop_ctl_reg[`CHGC_BIT_REDUCED];
  assign dif.host_mode  = host_reg;

  chgc_decode u_dec (
    .d (dif.dec)
  );

  // Decoded settings registered for clean outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_charge_mode <= 1'b1;
      term_tenth_mode <= 1'b1;
      chg_current_ma  <= 12'h000;
      term_current_ma <= 12'h000;
      vin_floor_mv    <= 13'h0000;
      host_mode       <= 1'b0;
    end else begin
      ext_charge_mode <= dif.ext_mode;
      term_tenth_mode <= dif.term_tenth;
      chg_current_ma  <= dif.chg_ma;
      term_current_ma <= dif.term_ma;
      vin_floor_mv    <= dif.vin_mv;
      host_mode       <= host_reg;
    end
  end

  // Loop, timer and power-path controls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loop_in_control  <= 3'b000;
      timer_half_speed <= 1'b0;
      batt_switch_off  <= 1'b0;
      ts_monitor_en    <= 1'b1;
    end else begin
      loop_in_control  <= {grant_reg == CHGC_LOOP_THERM, grant_reg == CHGC_LOOP_ILIM,
                           grant_reg == CHGC_LOOP_VIN};
      timer_half_speed <= tmr_reg[`CHGC_BIT_STRETCH] &&
                          (grant_reg == CHGC_LOOP_THERM || grant_reg == CHGC_LOOP_VIN ||
                           power_path_active);
      batt_switch_off  <= tmr_reg[`CHGC_BIT_ISOLATE] && !input_present;
      ts_monitor_en    <= tmr_reg[`CHGC_BIT_THERMISTOR_MONITOR_ENABLE];
    end
  end

  // Timer limit decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_limit_min <= `CHGC_TMR_MID_MIN;
      timer_disabled  <= 1'b0;
    end else begin
      unique case (tmr_reg[6:5])
        2'b00: timer_limit_min <= `CHGC_TMR_SHORT_MIN;
        2'b01: timer_limit_min <= `CHGC_TMR_MID_MIN;
        2'b10: timer_limit_min <= `CHGC_TMR_LONG_MIN;
        2'b11: timer_limit_min <= 10'h000;
      endcase
      timer_disabled <= (tmr_reg[6:5] == 2'b11);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_curr_decode;
    host_reg && !(&curr_reg[7:3]) && !loop_ctl_reg[`CHGC_BIT_REDUCED]
      |=> chg_current_ma == 12'(500 + 50 * $past(curr_reg[7:3]));
  endproperty
  a_curr_decode: assert property (p_curr_decode)
    else $error("charge current decode wrong");

  property p_ext_all_ones;
    (&curr_reg[7:3]) |=> ext_charge_mode && chg_current_ma == 12'h000;
  endproperty
  a_ext_all_ones: assert property (p_ext_all_ones)
    else $error("all-ones code not external");

  property p_curr_max;
    chg_current_ma <= 12'd2000;
  endproperty
  a_curr_max: assert property (p_curr_max)
    else $error("charge current above ceiling");

  property p_term_decode;
    host_reg && !(&curr_reg[7:3])
      |=> term_current_ma == 12'(50 + 25 * $past(curr_reg[2:0]));
  endproperty
  a_term_decode: assert property (p_term_decode)
    else $error("termination decode wrong");

  property p_term_tenth;
    ext_charge_mode |-> term_tenth_mode && term_current_ma == 12'h000;
  endproperty
  a_term_tenth: assert property (p_term_tenth)
    else $error("external mode termination not tenth");

  property p_status_hold;
    status_reg != CHGC_LOOP_NONE && !rd_loop |=> $stable(status_reg);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("loop status changed before read");

  property p_status_catch;
    status_reg == CHGC_LOOP_NONE && grant_reg != CHGC_LOOP_NONE
      |=> status_reg == $past(grant_reg);
  endproperty
  a_status_catch: assert property (p_status_catch)
    else $error("loop event not latched");

  property p_one_loop;
    $onehot0(loop_in_control);
  endproperty
  a_one_loop: assert property (p_one_loop)
    else $error("more than one loop in control");

  property p_reduced;
    host_reg && !(&curr_reg[7:3]) && loop_ctl_reg[`CHGC_BIT_REDUCED]
      |=> chg_current_ma == 12'd330;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("reduced current not applied");

  property p_detect;
    wr_loop && reg_wdata[`CHGC_BIT_DETECT] |=> detect_start ##1 !detect_start;
  endproperty
  a_detect: assert property (p_detect)
    else $error("detection start not a single pulse");

  property p_ce_read;
    rd_loop |=> reg_rdata[`CHGC_BIT_CE] == $past(ce_pin);
  endproperty
  a_ce_read: assert property (p_ce_read)
    else $error("charge enable status mismatch");

  property p_vin_floor;
    host_reg |=> vin_floor_mv == 13'(4200 + 80 * $past(loop_ctl_reg[2:0]));
  endproperty
  a_vin_floor: assert property (p_vin_floor)
    else $error("input floor decode wrong");

  property p_isolate;
    tmr_reg[`CHGC_BIT_ISOLATE] && !input_present |=> batt_switch_off;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("battery switch not opened");

  // Only a grant or a read may move the status; a host write never does
  property p_ro_ignore;
    (wr_loop || wr_tmr) && !rd_loop && grant_reg == CHGC_LOOP_NONE
      |=> $stable(status_reg) && tmr_reg[2:0] == 3'b000;
  endproperty
  a_ro_ignore: assert property (p_ro_ignore)
    else $error("write reached read-only bits");

  property p_detect_hold;
    detect_reg && !detect_done |=> detect_reg;
  endproperty
  a_detect_hold: assert property (p_detect_hold)
    else $error("detection bit dropped before completion");

  property p_detect_clear;
    detect_done && !(wr_loop && reg_wdata[`CHGC_BIT_DETECT]) |=> !detect_reg;
  endproperty
  a_detect_clear: assert property (p_detect_clear)
    else $error("detection bit not cleared on completion");

  property p_tmr_off;
    tmr_reg[6:5] == 2'b11 |=> timer_disabled && timer_limit_min == 10'h000;
  endproperty
  a_tmr_off: assert property (p_tmr_off)
    else $error("safety timer not disabled");

  property p_no_stretch;
    !tmr_reg[`CHGC_BIT_STRETCH] |=> !timer_half_speed;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("timer slowed with stretch off");

  property p_wdog_exit;
    wdog_expired && !wr_any |=> !host_reg;
  endproperty
  a_wdog_exit: assert property (p_wdog_exit)
    else $error("host mode kept after watchdog expiry");

  property p_ts_open_read;
    reg_rd && reg_addr == `CHGC_ADDR_TMR && !tmr_reg[`CHGC_BIT_THERMISTOR_MONITOR_ENABLE]
      |=> reg_rdata[2:0] == `CHGC_TS_OPEN;
  endproperty
  a_ts_open_read: assert property (p_ts_open_read)
    else $error("disabled thermistor not read as open");

  c_loop_latched: cover property (status_reg == CHGC_LOOP_NONE ##1 status_reg != CHGC_LOOP_NONE);
  c_detect_run:   cover property (detect_start ##[1:20] detect_done);
  c_reduced:      cover property (chg_current_ma == 12'd330);
  c_expiry:       cover property (host_reg ##1 !host_reg);
  c_contest:      cover property (therm_loop_req && ilim_loop_req && grant_reg == CHGC_LOOP_NONE);
endmodule : chgc_regs

// *** pkg/chgc_consts.svh ***
/*
  Offsets, field positions, reset values and decode constants of the charger
  configuration registers. Assumes it is included by its bare name.
*/
`ifndef CHGC_CONSTS_SVH
`define CHGC_CONSTS_SVH

`define CHGC_ADDR_CURR      8'h03
`define CHGC_ADDR_LOOP      8'h04
`define CHGC_ADDR_TMR       8'h05

`define CHGC_RST_CURR       8'hf8
`define CHGC_RST_LOOP       8'h02
`define CHGC_RST_TMR        8'ha8

`define CHGC_LOOP_RW_MASK   8'h37
`define CHGC_BIT_REDUCED    5
`define CHGC_BIT_DETECT     4
`define CHGC_BIT_CE         3
`define CHGC_BIT_STRETCH    7
`define CHGC_BIT_ISOLATE    4
`define CHGC_BIT_THERMISTOR_MONITOR_ENABLE      3

`define CHGC_FAST_CHARGE_CURRENT_OFS_MA    12'd500
`define CHGC_FAST_CHARGE_CURRENT_STEP_MA   12'd50
`define CHGC_FAST_CHARGE_CURRENT_MAX_MA    12'd2000
`define CHGC_REDUCED_MA     12'd330
`define CHGC_TERMINATION_CURRENT_OFS_MA   12'd50
`define CHGC_TERMINATION_CURRENT_STEP_MA  12'd25
`define CHGC_VIN_OFS_MV     13'd4200
`define CHGC_VIN_STEP_MV    13'd80

`define CHGC_TMR_SHORT_MIN  10'd45
`define CHGC_TMR_MID_MIN    10'd360
`define CHGC_TMR_LONG_MIN   10'd540
`define CHGC_TS_OPEN        3'h7

`endif

// *** pkg/chgc_pkg.sv ***
/*
  Types shared by the charger configuration register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package chgc_pkg;
  // Encoding order equals the reported loop status code
  typedef enum logic [1:0] {
    CHGC_LOOP_NONE,
    CHGC_LOOP_VIN,
    CHGC_LOOP_ILIM,
    CHGC_LOOP_THERM
  } chgc_loop_t;
endpackage : chgc_pkg

// *** pkg/chgc_dec_if.sv ***
/*
  Carrier between the register block and its setting decoder.
  Assumes both ends sit in the same clock domain.
*/
interface chgc_dec_if;
  logic [4:0]  fast_charge_current_code;
  logic [2:0]  termination_current_code;
  logic [2:0]  vin_code;
  logic        reduced;
  logic        host_mode;
  logic [11:0] chg_ma;
  logic [11:0] term_ma;
  logic [12:0] vin_mv;
  logic        ext_mode;
  logic        term_tenth;

  modport regs (output fast_charge_current_code, termination_current_code, vin_code, reduced, host_mode,
                input  chg_ma, term_ma, vin_mv, ext_mode, term_tenth);
  modport dec  (input  fast_charge_current_code, termination_current_code, vin_code, reduced, host_mode,
                output chg_ma, term_ma, vin_mv, ext_mode, term_tenth);
endinterface : chgc_dec_if

// *** core/chgc_decode.sv ***
/*
  Combinational decode of the programmed codes into currents and voltages.
  Assumes the register block supplies the codes and samples the results.
*/
`include "chgc_consts.svh"

module chgc_decode
  import chgc_pkg::*;
(
  chgc_dec_if.dec d
);
  // Offset plus code times step, shared by every linear field
  function automatic logic [12:0] chgc_lin(input logic [12:0] ofs, input logic [12:0] step,
                                           input logic [4:0] code);
    logic [17:0] prod;
    prod = step * code;
    return 13'(ofs + prod[12:0]);
  endfunction : chgc_lin

  logic [11:0] prog_ma;

  // External mode outside host mode or on all-ones code
  assign d.ext_mode   = !d.host_mode || (&d.fast_charge_current_code);
  assign d.term_tenth = d.ext_mode;
  assign prog_ma = 12'(chgc_lin({1'b0, `CHGC_FAST_CHARGE_CURRENT_OFS_MA}, {1'b0, `CHGC_FAST_CHARGE_CURRENT_STEP_MA},
                                d.fast_charge_current_code));

  // Charge current; clamp guards against any code past the ceiling
  always_comb begin
    if (d.ext_mode)
      d.chg_ma = 12'h000;
    else if (d.reduced)
      d.chg_ma = `CHGC_REDUCED_MA;
    else if (prog_ma > `CHGC_FAST_CHARGE_CURRENT_MAX_MA)
      d.chg_ma = `CHGC_FAST_CHARGE_CURRENT_MAX_MA;
    else
      d.chg_ma = prog_ma;
  end

  // Zero means the external resistor governs
  assign d.term_ma = d.ext_mode ? 12'h000 :
                     12'(chgc_lin({1'b0, `CHGC_TERMINATION_CURRENT_OFS_MA}, {1'b0, `CHGC_TERMINATION_CURRENT_STEP_MA},
                                  {2'b00, d.termination_current_code}));
  assign d.vin_mv  = d.host_mode ?
                     chgc_lin(`CHGC_VIN_OFS_MV, `CHGC_VIN_STEP_MV, {2'b00, d.vin_code}) :
                     13'h0000;
endmodule : chgc_decode

// *** sim/chgc_host_model.sv ***
/*
  Host model: issues single-byte register accesses on the byte-strobe port.
  Assumes the bench clock, and a design that takes strobes on the rising edge.
*/
module chgc_host_model (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // Byte write; released lines flip so stale values never pass for valid ones
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : wr

  // Byte read; data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
    @(posedge mclk);
    #1;
    data = reg_rdata;
  endtask : rd
endmodule : chgc_host_model

// *** sim/chgc_regs_tb.sv ***
/*
  Self-checking bench for the charger configuration registers.
  Assumes the host model for bus cycles and the design's constant header.
*/
`include "chgc_consts.svh"

module chgc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, wdog_expired, ce_pin, input_present, detect_done;
  logic        vin_loop_req, ilim_loop_req, therm_loop_req, power_path_active;
  logic        detect_start, host_mode, ext_charge_mode, term_tenth_mode;
  logic        timer_half_speed, timer_disabled, batt_switch_off, ts_monitor_en;
  logic [11:0] chg_current_ma, term_current_ma;
  logic [12:0] vin_floor_mv;
  logic [2:0]  loop_in_control, ts_fault_in;
  logic [9:0]  timer_limit_min;
  int          bad_count = 0;
  int          n_checks = 0;

  always #50 mclk = ~mclk;

  chgc_regs DUT (
    .mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .wdog_expired, .ce_pin, .input_present, .vin_loop_req, .ilim_loop_req,
    .therm_loop_req, .power_path_active, .ts_fault_in, .detect_done, .detect_start,
    .host_mode, .ext_charge_mode, .term_tenth_mode, .chg_current_ma, .term_current_ma,
    .vin_floor_mv, .loop_in_control, .timer_half_speed, .timer_limit_min,
    .timer_disabled, .batt_switch_off, .ts_monitor_en
  );

  chgc_host_model host (
    .mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata
  );

  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // Compare a port output
  task automatic chk_out(input logic [12:0] got, input logic [12:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_out

  // Compare a register read
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.rd(addr, d);
    n_checks++;
    if (d !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s read %h exp %h", $time, what, d, exp);
    end
  endtask : rd_chk

  // Reset contents, standalone outputs, unmapped offset
  task automatic t_reset();
    rd_chk(8'h03, 8'hf8, "r03");                 // reset value
    rd_chk(8'h04, 8'h0a, "r04");                 // reset value
    rd_chk(8'h05, 8'had, "r05");                 // reset value
    chk_out(ext_charge_mode, 1'b1, "ext");       // external default
    chk_out(timer_limit_min, 10'h168, "lim");    // six hours
    chk_out(ts_monitor_en, 1'b1, "tsen");        // monitor on
    host.wr(8'h07, 8'h40);
    step(2);
    chk_out(host_mode, 1'b0, "unmapped wr");     // no host mode
    rd_chk(8'h07, 8'h00, "unmapped rd");
    $display("test reset done");
  endtask : t_reset

  // Loop arbitration, status latch and clear-on-read, timer stretch
  task automatic t_loops();
    vin_loop_req = 1'b1;
    step(3);
    chk_out(loop_in_control, 3'h1, "vin");      // single loop
    chk_out(timer_half_speed, 1'b1, "half");    // stretched
    vin_loop_req = 1'b0;
    step(3);
    therm_loop_req = 1'b1;
    step(3);
    chk_out(loop_in_control, 3'h4, "therm");    // single loop
    therm_loop_req = 1'b0;
    step(3);
    rd_chk(8'h04, 8'h4a, "first");              // first event held
    rd_chk(8'h04, 8'h0a, "cleared");            // cleared by read
    ilim_loop_req = 1'b1;
    step(3);
    chk_out(loop_in_control, 3'h2, "ilim");     // single loop
    chk_out(timer_half_speed, 1'b0, "nohalf");  // not stretched
    ilim_loop_req = 1'b0;
    step(3);
    rd_chk(8'h04, 8'h8a, "ilim st");            // current limit code
    ilim_loop_req = 1'b1;
    therm_loop_req = 1'b1;
    step(3);
    chk_out(loop_in_control, 3'h4, "both");     // one winner
    rd_chk(8'h04, 8'hca, "therm st");           // thermal code
    ilim_loop_req = 1'b0;
    therm_loop_req = 1'b0;
    step(3);
    rd_chk(8'h04, 8'hca, "therm hold");         // held until read
    $display("test loops done");
  endtask : t_loops

  // Charge and termination decode, reduced current, input floor, status bits
  task automatic t_charge();
    logic [4:0] c[5] = '{5'h00, 5'h01, 5'h0f, 5'h1e, 5'h1f};
    logic [2:0] t[5] = '{3'h0, 3'h7, 3'h3, 3'h5, 3'h2};
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h03, {c[i], t[i]});
      step(2);
      chk_out(host_mode, 1'b1, "host");                         // host mode
      chk_out(ext_charge_mode, c[i] == 5'h1f, "ext");           // all ones
      chk_out(term_tenth_mode, c[i] == 5'h1f, "tenth");         // tenth
      if (c[i] != 5'h1f) begin
        chk_out(chg_current_ma, `CHGC_FAST_CHARGE_CURRENT_OFS_MA + `CHGC_FAST_CHARGE_CURRENT_STEP_MA * c[i], "chg");
        chk_out(term_current_ma, `CHGC_TERMINATION_CURRENT_OFS_MA + `CHGC_TERMINATION_CURRENT_STEP_MA * t[i], "term");
      end
    end
    ce_pin = 1'b0;
    host.wr(8'h03, 8'h40);
    host.wr(8'h04, 8'hef);
    step(2);
    chk_out(chg_current_ma, 12'h14a, "reduced");      // 330 mA
    chk_out(vin_floor_mv, 13'h1298, "floor");         // 4.76 V
    rd_chk(8'h04, 8'h27, "r04 ro");                   // status bits kept
    host.wr(8'h04, 8'h00);
    step(2);
    chk_out(chg_current_ma, 12'h384, "normal");       // field governs
    chk_out(vin_floor_mv, 13'h1068, "floor0");        // 4.20 V
    ce_pin = 1'b1;
    $display("test charge done");
  endtask : t_charge

  // Detection trigger pulse and self-clear
  task automatic t_detect();
    // The start pulse stands only in the cycle right after the write edge
    host.wr(8'h04, 8'h12);
    chk_out(detect_start, 1'b1, "start");   // run starts
    step(1);
    chk_out(detect_start, 1'b0, "once");    // one run
    rd_chk(8'h04, 8'h1a, "busy");           // bit holds
    detect_done = 1'b1;
    step(1);
    detect_done = 1'b0;
    rd_chk(8'h04, 8'h0a, "done");           // bit clears
    $display("test detect done");
  endtask : t_detect

  // Timer limits, stretch, isolation, thermistor
  task automatic t_timer();
    logic [9:0] lim[4] = '{10'h02d, 10'h168, 10'h21c, 10'h000};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h05, {1'b1, 2'(i), 5'h08});
      step(2);
      chk_out(timer_limit_min, lim[i], "limit");     // limit code
      chk_out(timer_disabled, i == 3, "disabled");   // off code
    end
    power_path_active = 1'b1;
    host.wr(8'h05, 8'h28);
    step(2);
    chk_out(timer_half_speed, 1'b0, "nostretch");    // stretch off
    host.wr(8'h05, 8'ha8);
    step(2);
    chk_out(timer_half_speed, 1'b1, "stretch");      // path loop
    power_path_active = 1'b0;
    host.wr(8'h05, 8'h37);
    step(2);
    chk_out(ts_monitor_en, 1'b0, "ts off");          // monitor off
    rd_chk(8'h05, 8'h37, "ts open");                 // open code
    input_present = 1'b0;
    step(2);
    chk_out(batt_switch_off, 1'b1, "iso");           // isolated
    input_present = 1'b1;
    step(2);
    chk_out(batt_switch_off, 1'b0, "noiso");         // reconnected
    host.wr(8'h05, 8'h2f);
    for (int k = 0; k < 8; k++) begin
      ts_fault_in = 3'(k);
      step(2);
      rd_chk(8'h05, {5'h05, 3'(k)}, "ts code");      // fault code, writes ignored
    end
    chk_out(ts_monitor_en, 1'b1, "ts on");           // monitor on
    $display("test timer done");
  endtask : t_timer

  // Watchdog return to standalone, then a reset in mid-run
  task automatic t_wdog();
    wdog_expired = 1'b1;
    step(1);
    wdog_expired = 1'b0;
    step(2);
    chk_out(host_mode, 1'b0, "wdog");          // standalone
    chk_out(ext_charge_mode, 1'b1, "wext");    // external
    chk_out(vin_floor_mv, 13'h0, "wfloor");    // external floor
    rst_n = 1'b0;
    step(1);
    rst_n = 1'b1;
    rd_chk(8'h03, 8'hf8, "rr03");              // reset again
    rd_chk(8'h05, 8'haf, "rr05");              // reset again
    $display("test wdog done");
  endtask : t_wdog

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED at %0t: run timeout", $time);
    report_and_stop();
  end

  // Main sequence
  initial begin
    wdog_expired = 1'b0;
    ce_pin = 1'b1;
    input_present = 1'b1;
    detect_done = 1'b0;
    vin_loop_req = 1'b0;
    ilim_loop_req = 1'b0;
    therm_loop_req = 1'b0;
    power_path_active = 1'b0;
    ts_fault_in = 3'h5;
    step(3);
    rst_n = 1'b1;
    t_reset();
    t_loops();
    t_charge();
    t_detect();
    t_timer();
    t_wdog();
    report_and_stop();
  end
endmodule : chgc_regs_tb
